// File: inc/faod_map.vh
// Constants for the floating-point arithmetic dispatch block.
// Assumes inclusion by bare name from design and bench files.
`ifndef FAOD_MAP_VH
`define FAOD_MAP_VH

// Source data formats
`define FAOD_FMT_L     3'h0
`define FAOD_FMT_S     3'h1
`define FAOD_FMT_X     3'h2
`define FAOD_FMT_P     3'h3
`define FAOD_FMT_W     3'h4
`define FAOD_FMT_D     3'h5
`define FAOD_FMT_B     3'h6
`define FAOD_FMT_NONE  3'h7

// Source location
`define FAOD_SRC_MEM   2'h0
`define FAOD_SRC_DREG  2'h1
`define FAOD_SRC_FPREG 2'h2

// Rounding precision
`define FAOD_PREC_X    2'h0
`define FAOD_PREC_S    2'h1
`define FAOD_PREC_D    2'h2

// Rounding modes
`define FAOD_RM_NEAR   2'h0
`define FAOD_RM_ZERO   2'h1

// Operation specifiers, monadic
`define FAOD_ABS       7'h01
`define FAOD_ACOS      7'h02
`define FAOD_ASIN      7'h03
`define FAOD_ATAN      7'h04
`define FAOD_ATANH     7'h05
`define FAOD_COS       7'h06
`define FAOD_COSH      7'h07
`define FAOD_ETOX      7'h08
`define FAOD_ETOXM1    7'h09
`define FAOD_GETEXP    7'h0a
`define FAOD_GETMAN    7'h0b
`define FAOD_INT       7'h0c
`define FAOD_INTRZ     7'h0d
`define FAOD_LOGN      7'h0e
`define FAOD_LOGNP1    7'h0f
`define FAOD_LOG10     7'h10
`define FAOD_LOG2      7'h11
`define FAOD_NEG       7'h12
`define FAOD_SIN       7'h13
`define FAOD_SINH      7'h14
`define FAOD_SQRT      7'h15
`define FAOD_TAN       7'h16
`define FAOD_TANH      7'h17
`define FAOD_TENTOX    7'h18
`define FAOD_TWOTOX    7'h19

// Operation specifiers, dyadic
`define FAOD_ADD       7'h20
`define FAOD_CMP       7'h21
`define FAOD_DIV       7'h22
`define FAOD_MOD       7'h23
`define FAOD_MUL       7'h24
`define FAOD_REM       7'h25
`define FAOD_SCALE     7'h26
`define FAOD_SUB       7'h27
`define FAOD_SGLDIV    7'h28
`define FAOD_SGLMUL    7'h29
`define FAOD_ADD_S     7'h40
`define FAOD_DIV_S     7'h41
`define FAOD_MUL_S     7'h42
`define FAOD_SUB_S     7'h43
`define FAOD_ADD_D     7'h44
`define FAOD_DIV_D     7'h45
`define FAOD_MUL_D     7'h46
`define FAOD_SUB_D     7'h47

`endif

// File: rtl/faod_optab.v
// Operation table: maps an operation specifier to its function.
// Assumes a combinational caller on the same clock.
`timescale 1ns/10ps
`include "faod_map.vh"

module faod_optab (
  // Specifier
  input  wire [6:0] op,
  // Decoded function
  output reg        known,
  output reg        dyadic,
  output reg  [6:0] base_op,
  output reg        prec_force,
  output reg  [1:0] prec_val,
  output reg        force_rz,
  output reg        writes
);

  always @* begin
    known      = 1'b1;
    dyadic     = 1'b0;
    base_op    = op;
    prec_force = 1'b0;
    prec_val   = `FAOD_PREC_X;
    force_rz   = 1'b0;
    writes     = 1'b1;
    case (op)
      `FAOD_ABS, `FAOD_NEG, `FAOD_SQRT, `FAOD_GETEXP, `FAOD_GETMAN,
      `FAOD_ACOS, `FAOD_ASIN, `FAOD_ATAN, `FAOD_COS, `FAOD_SIN, `FAOD_TAN,
      `FAOD_ATANH, `FAOD_COSH, `FAOD_SINH, `FAOD_TANH,
      `FAOD_ETOX, `FAOD_ETOXM1, `FAOD_TWOTOX, `FAOD_TENTOX,
      `FAOD_LOGN, `FAOD_LOGNP1, `FAOD_LOG10, `FAOD_LOG2,
      `FAOD_INT: begin
        known = 1'b1;
      end
      `FAOD_INTRZ: begin
        force_rz = 1'b1;
      end
      `FAOD_ADD, `FAOD_DIV, `FAOD_MOD, `FAOD_MUL,
      `FAOD_REM, `FAOD_SCALE, `FAOD_SUB: begin
        dyadic = 1'b1;
      end
      `FAOD_CMP: begin
        dyadic = 1'b1;
        writes = 1'b0;
      end
      `FAOD_SGLDIV, `FAOD_SGLMUL: begin
        dyadic     = 1'b1;
        prec_force = 1'b1;
        prec_val   = `FAOD_PREC_S;
      end
      `FAOD_ADD_S, `FAOD_DIV_S, `FAOD_MUL_S, `FAOD_SUB_S: begin
        dyadic     = 1'b1;
        prec_force = 1'b1;
        prec_val   = `FAOD_PREC_S;
        base_op    = {3'h2, op[3:0] == 4'h0 ? 4'h0 : op[3:0] == 4'h1 ? 4'h2 :
                      op[3:0] == 4'h2 ? 4'h4 : 4'h7};
      end
      `FAOD_ADD_D, `FAOD_DIV_D, `FAOD_MUL_D, `FAOD_SUB_D: begin
        dyadic     = 1'b1;
        prec_force = 1'b1;
        prec_val   = `FAOD_PREC_D;
        base_op    = {3'h2, op[3:0] == 4'h4 ? 4'h0 : op[3:0] == 4'h5 ? 4'h2 :
                      op[3:0] == 4'h6 ? 4'h4 : 4'h7};
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule

// File: rtl/faod_dispatch.v
// Floating-point arithmetic dispatch: decodes one command and
// presents operand routing, function and rounding to the executor.
// Assumes command and executor logic run on clk; no inputs except
// the async reset rst are asynchronous to it.
//
// How it works
// - Dyadic first operand comes from memory, integer register or FP register.
// - Dyadic second operand always read from the FP destination register.
// - Dyadic result, except for cmp, written back to the register giving the second operand.
// - Memory or integer sources take any format; register sources only extended.
// - Result precision follows the variant or single div/mul, else the current precision mode.
// - Dyadic set: add, cmp, div, mod, mul, rem, scale, sub, single div/mul, variants.
// - Monadic source and destination may differ; source kept unless identical.
// - Monadic destination is always an FP data register.
// - Monadic non-FP source accepts every supported format.
// - Monadic FP-to-FP and in-place forms use extended format.
// - Monadic set: abs, neg, sqrt, trig, exp, log, exponent, mantissa, integer.
// - Two integer-part ops: current rounding and always toward zero.
`timescale 1ns/10ps
`include "faod_map.vh"

module faod_dispatch (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Command from the integer unit
  input  wire       cmd_valid,
  input  wire [6:0] cmd_op,
  input  wire [1:0] cmd_src_loc,
  input  wire [2:0] cmd_src_fmt,
  input  wire [2:0] cmd_src_reg,
  input  wire [2:0] cmd_dst_reg,
  input  wire       cmd_in_place,
  output wire       cmd_ready,
  // Current rounding control
  input  wire [1:0] mode_prec,
  input  wire [1:0] mode_rnd,
  // Dispatch to the executor
  output wire       dsp_valid,
  input  wire       dsp_ready,
  output wire       dsp_illegal,
  output wire [6:0] dsp_func,
  output wire       dsp_dyadic,
  output wire [1:0] dsp_src_loc,
  output wire [2:0] dsp_src_fmt,
  output wire [2:0] dsp_src_reg,
  output wire       dsp_opb_en,
  output wire [2:0] dsp_opb_reg,
  output wire       dsp_wr_en,
  output wire [2:0] dsp_wr_reg,
  output wire       dsp_src_kept,
  output wire [1:0] dsp_prec,
  output wire [1:0] dsp_rnd
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;

  reg        cmd_ready_ff;
  reg        dsp_valid_ff;
  reg        dsp_illegal_ff;
  reg  [6:0] dsp_func_ff;
  reg        dsp_dyadic_ff;
  reg  [1:0] dsp_src_loc_ff;
  reg  [2:0] dsp_src_fmt_ff;
  reg  [2:0] dsp_src_reg_ff;
  reg        dsp_opb_en_ff;
  reg  [2:0] dsp_opb_reg_ff;
  reg        dsp_wr_en_ff;
  reg  [2:0] dsp_wr_reg_ff;
  reg        dsp_src_kept_ff;
  reg  [1:0] dsp_prec_ff;
  reg  [1:0] dsp_rnd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Operation table

  wire       tb_known;
  wire       tb_dyadic;
  wire [6:0] tb_base_op;
  wire       tb_prec_force;
  wire [1:0] tb_prec_val;
  wire       tb_force_rz;
  wire       tb_writes;

  faod_optab u_optab (
    .op         (cmd_op),
    .known      (tb_known),
    .dyadic     (tb_dyadic),
    .base_op    (tb_base_op),
    .prec_force (tb_prec_force),
    .prec_val   (tb_prec_val),
    .force_rz   (tb_force_rz),
    .writes     (tb_writes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand routing and checks

  reg        src_is_fp;
  reg        loc_ok;
  reg        fmt_ok;
  reg        form_ok;
  reg  [2:0] eff_fmt;
  reg  [2:0] eff_src_reg;
  reg        src_same;
  reg        src_kept;
  reg  [1:0] eff_prec;
  reg  [1:0] eff_rnd;
  reg        legal;

  // Source location; the in-place form always reads an FP register
  always @* begin
    src_is_fp = 1'b0;
    loc_ok    = 1'b0;
    case (cmd_src_loc)
      `FAOD_SRC_MEM: begin
        loc_ok = 1'b1;
      end
      `FAOD_SRC_DREG: begin
        loc_ok = 1'b1;
      end
      `FAOD_SRC_FPREG: begin
        loc_ok    = 1'b1;
        src_is_fp = 1'b1;
      end
      default: begin
        loc_ok = 1'b0;
      end
    endcase
    if (cmd_in_place) begin
      src_is_fp = 1'b1;
    end
  end

  // FP register sources are always extended; others take any defined format
  always @* begin
    eff_fmt = cmd_src_fmt;
    fmt_ok  = 1'b0;
    if (src_is_fp) begin
      eff_fmt = `FAOD_FMT_X;
      fmt_ok  = 1'b1;
    end else begin
      case (cmd_src_fmt)
        `FAOD_FMT_B, `FAOD_FMT_W, `FAOD_FMT_L, `FAOD_FMT_S,
        `FAOD_FMT_D, `FAOD_FMT_X, `FAOD_FMT_P: begin
          fmt_ok = 1'b1;
        end
        default: begin
          fmt_ok = 1'b0;
        end
      endcase
    end
  end

  // In-place form reads and writes the destination register
  always @* begin
    eff_src_reg = cmd_in_place ? cmd_dst_reg : cmd_src_reg;
    src_same    = src_is_fp & (eff_src_reg == cmd_dst_reg);
    // Source is lost only when it is the register actually written
    src_kept    = ~(src_same & tb_writes & legal);
  end

  // Variants and single div/mul force their precision; else the mode, code 3 read as extended
  always @* begin
    if (tb_prec_force) begin
      eff_prec = tb_prec_val;
    end else begin
      case (mode_prec)
        `FAOD_PREC_S: begin
          eff_prec = `FAOD_PREC_S;
        end
        `FAOD_PREC_D: begin
          eff_prec = `FAOD_PREC_D;
        end
        default: begin
          eff_prec = `FAOD_PREC_X;
        end
      endcase
    end
  end

  always @* begin
    eff_rnd = tb_force_rz ? `FAOD_RM_ZERO : mode_rnd;
    // In-place form exists only for monadic operations
    form_ok = ~(cmd_in_place & tb_dyadic);
    legal   = tb_known & loc_ok & fmt_ok & form_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake state machine

  always @* begin
    case (state_ff)
      ST_IDLE: begin
        nxt_state = (cmd_valid & cmd_ready_ff) ? ST_HOLD : ST_IDLE;
      end
      ST_HOLD: begin
        nxt_state = dsp_ready ? ST_IDLE : ST_HOLD;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready and valid follow the next state so both leave flip-flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ready_ff <= 1'b0;
      dsp_valid_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= (nxt_state == ST_IDLE);
      dsp_valid_ff <= (nxt_state == ST_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch word, captured when a command is taken

  // A command is taken only in idle while ready is shown
  wire take = (state_ff == ST_IDLE) & cmd_valid & cmd_ready_ff;

  // Function and enables; a rejected command gets no effects
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dsp_illegal_ff  <= 1'b0;
      dsp_func_ff     <= 7'h00;
      dsp_dyadic_ff   <= 1'b0;
      dsp_opb_en_ff   <= 1'b0;
      dsp_wr_en_ff    <= 1'b0;
      dsp_src_kept_ff <= 1'b1;
    end else if (take) begin
      dsp_illegal_ff  <= ~legal;
      dsp_func_ff     <= legal ? tb_base_op : 7'h00;
      dsp_dyadic_ff   <= legal & tb_dyadic;
      dsp_opb_en_ff   <= legal & tb_dyadic;
      dsp_wr_en_ff    <= legal & tb_writes;
      dsp_src_kept_ff <= src_kept;
    end
  end

  // Operand routing; loaded for rejected commands as well
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dsp_src_loc_ff  <= `FAOD_SRC_MEM;
      dsp_src_fmt_ff  <= `FAOD_FMT_X;
      dsp_src_reg_ff  <= 3'h0;
      dsp_opb_reg_ff  <= 3'h0;
      dsp_wr_reg_ff   <= 3'h0;
    end else if (take) begin
      dsp_src_loc_ff  <= src_is_fp ? `FAOD_SRC_FPREG : cmd_src_loc;
      dsp_src_fmt_ff  <= eff_fmt;
      dsp_src_reg_ff  <= eff_src_reg;
      dsp_opb_reg_ff  <= cmd_dst_reg;
      dsp_wr_reg_ff   <= cmd_dst_reg;
    end
  end

  // Rounding precision and mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dsp_prec_ff     <= `FAOD_PREC_X;
      dsp_rnd_ff      <= `FAOD_RM_NEAR;
    end else if (take) begin
      dsp_prec_ff     <= eff_prec;
      dsp_rnd_ff      <= eff_rnd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd_ready    = cmd_ready_ff;
  assign dsp_valid    = dsp_valid_ff;
  assign dsp_illegal  = dsp_illegal_ff;
  assign dsp_func     = dsp_func_ff;
  assign dsp_dyadic   = dsp_dyadic_ff;
  assign dsp_src_loc  = dsp_src_loc_ff;
  assign dsp_src_fmt  = dsp_src_fmt_ff;
  assign dsp_src_reg  = dsp_src_reg_ff;
  assign dsp_opb_en   = dsp_opb_en_ff;
  assign dsp_opb_reg  = dsp_opb_reg_ff;
  assign dsp_wr_en    = dsp_wr_en_ff;
  assign dsp_wr_reg   = dsp_wr_reg_ff;
  assign dsp_src_kept = dsp_src_kept_ff;
  assign dsp_prec     = dsp_prec_ff;
  assign dsp_rnd      = dsp_rnd_ff;

endmodule

// File: test/faod_dispatch_sva.sv
// Checker for the dispatch block: handshake and word fields.
// Assumes one clock and an active-high async reset.
`timescale 1ns/10ps
`include "faod_map.vh"
module faod_dispatch_sva (
  input wire       clk, rst, cmd_valid, cmd_in_place, cmd_ready, dsp_valid, dsp_ready,
  input wire       dsp_illegal, dsp_dyadic, dsp_opb_en, dsp_wr_en, dsp_src_kept,
  input wire [6:0] cmd_op, dsp_func,
  input wire [1:0] cmd_src_loc, mode_prec, mode_rnd, dsp_src_loc, dsp_prec, dsp_rnd,
  input wire [2:0] cmd_src_fmt, cmd_src_reg, cmd_dst_reg, dsp_src_fmt, dsp_src_reg, dsp_opb_reg, dsp_wr_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take; cmd_valid && cmd_ready; endsequence
  sequence s_done; dsp_valid && dsp_ready; endsequence
  chk_take_answer: assert property (s_take |=> dsp_valid && !cmd_ready)
    else $error("no dispatch word after take");
  chk_word_hold: assert property (dsp_valid && !dsp_ready |=> dsp_valid && $stable(dsp_func))
    else $error("dispatch word not held");
  chk_release: assert property (s_done |=> !dsp_valid && cmd_ready)
    else $error("dispatch not released");
  chk_illegal_quiet: assert property (dsp_valid && dsp_illegal |-> !dsp_wr_en && !dsp_opb_en && dsp_func == 7'h00)
    else $error("rejected command has effects");
  chk_fp_ext_fmt: assert property (dsp_valid && dsp_src_loc == `FAOD_SRC_FPREG |-> dsp_src_fmt == `FAOD_FMT_X)
    else $error("register source not extended");
  chk_dest_regs: assert property (s_take |=> dsp_opb_reg == $past(cmd_dst_reg) && dsp_wr_reg == $past(cmd_dst_reg))
    else $error("destination register wrong");
  chk_dyadic_opb: assert property (dsp_valid && dsp_dyadic |-> dsp_opb_en && !dsp_illegal)
    else $error("second operand not read");
  chk_mon_write: assert property (dsp_valid && !dsp_illegal && !dsp_dyadic |-> dsp_wr_en)
    else $error("monadic result not written");
  chk_rz_force: assert property (s_take ##0 cmd_op == `FAOD_INTRZ |=> dsp_rnd == `FAOD_RM_ZERO)
    else $error("toward zero not forced");
  chk_src_kept: assert property (dsp_valid && dsp_wr_en && dsp_src_reg != dsp_wr_reg |-> dsp_src_kept)
    else $error("distinct source not kept");
  chk_var_prec: assert property (s_take ##0 cmd_op == `FAOD_ADD_D |=> dsp_prec == `FAOD_PREC_D || dsp_illegal)
    else $error("double variant precision wrong");
endmodule
bind faod_dispatch faod_dispatch_sva u_faod_dispatch_sva (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_in_place(cmd_in_place), .cmd_ready(cmd_ready), .dsp_valid(dsp_valid), .dsp_ready(dsp_ready),
  .dsp_illegal(dsp_illegal), .dsp_dyadic(dsp_dyadic), .dsp_opb_en(dsp_opb_en), .dsp_wr_en(dsp_wr_en),
  .dsp_src_kept(dsp_src_kept), .cmd_op(cmd_op), .dsp_func(dsp_func), .cmd_src_loc(cmd_src_loc),
  .mode_prec(mode_prec), .mode_rnd(mode_rnd), .dsp_src_loc(dsp_src_loc), .dsp_prec(dsp_prec), .dsp_rnd(dsp_rnd),
  .cmd_src_fmt(cmd_src_fmt), .cmd_src_reg(cmd_src_reg), .cmd_dst_reg(cmd_dst_reg), .dsp_src_fmt(dsp_src_fmt),
  .dsp_src_reg(dsp_src_reg), .dsp_opb_reg(dsp_opb_reg), .dsp_wr_reg(dsp_wr_reg));

// File: test/faod_exec_model.sv
// Executor model: accepts dispatch words, promptly or with stalls.
// Assumes the bench sets the pace and one clock.
`timescale 1ns/10ps
module faod_exec_model (
  // Clock and pace
  input  wire clk,
  input  wire rst,
  input  wire slow,
  // Dispatch handshake
  input  wire dsp_valid,
  output reg  dsp_ready
);
  reg [1:0] cnt_ff;
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 2'h0;
      dsp_ready <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      dsp_ready <= dsp_valid && (!slow || cnt_ff == 2'h3);
    end
  end
endmodule

// File: test/tb.sv
// Bench for the dispatch block: opcode sweep plus routing cases.
// Assumes the executor model and the bound checker.
`timescale 1ns/10ps
`include "faod_map.vh"
module tb;
  reg        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_in_place = 1'b0, slow = 1'b0, prev_v = 1'b0;
  reg [6:0]  cmd_op = 7'h00;
  reg [1:0]  cmd_src_loc = 2'h0, mode_prec = 2'h0, mode_rnd = 2'h0;
  reg [2:0]  cmd_src_fmt = 3'h0, cmd_src_reg = 3'h0, cmd_dst_reg = 3'h0;
  wire       cmd_ready, dsp_valid, dsp_ready, dsp_illegal, dsp_dyadic, dsp_opb_en, dsp_wr_en, dsp_src_kept;
  wire [6:0] dsp_func;
  wire [1:0] dsp_src_loc, dsp_prec, dsp_rnd;
  wire [2:0] dsp_src_fmt, dsp_src_reg, dsp_opb_reg, dsp_wr_reg;
  integer    error_cnt = 0, check_count = 0, seed = 32'hc571b160, i, n;
  reg [31:0] r;
  reg [29:0] e, m, e_note;
  reg [59:0] q[$];
  wire [29:0] dsp_word = {dsp_illegal, dsp_func, dsp_dyadic, dsp_src_loc, dsp_src_fmt, dsp_src_reg, dsp_opb_en,
                          dsp_opb_reg, dsp_wr_en, dsp_wr_reg, dsp_src_kept, dsp_prec, dsp_rnd};
  always #10 clk = ~clk;
  faod_dispatch u_faod_dispatch (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_src_loc(cmd_src_loc), .cmd_src_fmt(cmd_src_fmt), .cmd_src_reg(cmd_src_reg), .cmd_dst_reg(cmd_dst_reg),
    .cmd_in_place(cmd_in_place), .cmd_ready(cmd_ready), .mode_prec(mode_prec), .mode_rnd(mode_rnd),
    .dsp_valid(dsp_valid), .dsp_ready(dsp_ready), .dsp_illegal(dsp_illegal), .dsp_func(dsp_func),
    .dsp_dyadic(dsp_dyadic), .dsp_src_loc(dsp_src_loc), .dsp_src_fmt(dsp_src_fmt), .dsp_src_reg(dsp_src_reg),
    .dsp_opb_en(dsp_opb_en), .dsp_opb_reg(dsp_opb_reg), .dsp_wr_en(dsp_wr_en), .dsp_wr_reg(dsp_wr_reg),
    .dsp_src_kept(dsp_src_kept), .dsp_prec(dsp_prec), .dsp_rnd(dsp_rnd));
  faod_exec_model u_faod_exec_model (.clk(clk), .rst(rst), .slow(slow), .dsp_valid(dsp_valid),
    .dsp_ready(dsp_ready));
  //////////////////////////////////////////////////////////////////////////////
  function [29:0] exp_word(input [6:0] op, input [1:0] loc, pr, rm, input [2:0] fmt, sr, dr, input ip);
    reg dy, fp, ill, wr;
    reg [6:0] f;
    reg [1:0] p;
    begin
      dy = (op >= 7'h20 && op <= 7'h29) || (op >= 7'h40 && op <= 7'h47);
      fp = ip || loc == `FAOD_SRC_FPREG;
      ill = !(dy || (op >= 7'h01 && op <= 7'h19)) || (loc == 2'h3) || (!fp && fmt == `FAOD_FMT_NONE) || (ip && dy);
      f = !op[6] ? op : op[1:0] == 2'h0 ? `FAOD_ADD : op[1:0] == 2'h1 ? `FAOD_DIV : op[1:0] == 2'h2 ? `FAOD_MUL : `FAOD_SUB;
      wr = !ill && op != `FAOD_CMP;
      p = (op == `FAOD_SGLDIV || op == `FAOD_SGLMUL || op[6:2] == 5'h10) ? `FAOD_PREC_S :
          op[6:2] == 5'h11 ? `FAOD_PREC_D : pr == 2'h3 ? `FAOD_PREC_X : pr;
      exp_word = {ill, ill ? 7'h00 : f, dy && !ill, fp ? `FAOD_SRC_FPREG : loc, fp ? `FAOD_FMT_X : fmt, ip ? dr : sr,
                  dy && !ill, dr, wr, dr, !(fp && (ip || sr == dr) && wr), p, op == `FAOD_INTRZ ? `FAOD_RM_ZERO : rm};
    end
  endfunction
  // Offers a command; it stays offered until taken, then the note is queued
  task send(input [6:0] op, input [1:0] loc, input [2:0] fmt, sr, dr, input ip);
    begin
      @(negedge clk);
      r = $random(seed);
      {cmd_op, cmd_src_loc, cmd_src_fmt, cmd_src_reg, cmd_dst_reg, cmd_in_place, cmd_valid} = {op, loc, fmt, sr, dr, ip, 1'b1};
      {mode_prec, mode_rnd, slow} = r[4:0];
      e = exp_word(op, loc, r[4:3], r[2:1], fmt, sr, dr, ip);
      n = 0;
      while (!cmd_ready && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      if (cmd_ready !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("wrong value cmd_ready expected 1 seen %b", cmd_ready);
      end
      @(posedge clk);
      q.push_back({e[29] ? 30'h3fe0_1ff0 : 30'h3fff_ffff, e});
    end
  endtask
  always @(negedge clk) begin
    prev_v <= dsp_valid;
    if (dsp_valid && !prev_v) begin
      {m, e_note} = q.size() ? q.pop_front() : 60'hfff_ffff_f000_0000;
      check_count = check_count + 1;
      if ((dsp_word & m) !== (e_note & m)) begin
        error_cnt = error_cnt + 1;
        $display("wrong value dispatch word expected %h seen %h", e_note & m, dsp_word & m);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 256; i = i + 1) begin
      r = $random(seed);
      send(i[6:0], r[1:0], r[4:2], r[7:5], r[10:8], r[11] & r[12]);
    end
    $display("test opcode sweep done");
    for (i = 0; i < 8; i = i + 1) begin
      send(i[0] ? `FAOD_SQRT : `FAOD_DIV_S, i[1] ? `FAOD_SRC_DREG : `FAOD_SRC_MEM, i[2:0], 3'h1, 3'h2, 1'b0);
    end
    $display("test source formats done");
    send(`FAOD_NEG, `FAOD_SRC_FPREG, `FAOD_FMT_B, 3'h3, 3'h3, 1'b0);
    send(`FAOD_ABS, `FAOD_SRC_FPREG, `FAOD_FMT_P, 3'h4, 3'h5, 1'b0);
    send(`FAOD_INT, `FAOD_SRC_MEM, `FAOD_FMT_D, 3'h0, 3'h6, 1'b1);
    send(`FAOD_ADD, `FAOD_SRC_DREG, `FAOD_FMT_W, 3'h0, 3'h7, 1'b1);
    send(`FAOD_CMP, `FAOD_SRC_FPREG, `FAOD_FMT_X, 3'h2, 3'h2, 1'b0);
    send(`FAOD_SUB, `FAOD_SRC_FPREG, `FAOD_FMT_L, 3'h1, 3'h0, 1'b0);
    send(`FAOD_INTRZ, `FAOD_SRC_DREG, `FAOD_FMT_S, 3'h0, 3'h1, 1'b0);
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (20) @(negedge clk);
    if (q.size() != 0) begin
      error_cnt = error_cnt + 1;
      $display("wrong value pending notes expected 0 seen %0d", q.size());
    end
    $display("test register routing done");
    final_report;
  end
endmodule
